// ==== logic/pin_function_config_defines.svh ====
`ifndef PIN_FUNCTION_CONFIG_DEFINES_SVH
`define PIN_FUNCTION_CONFIG_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PFC_CFG_OFFSET      8'h88
`define PFC_EVT_STS_OFFSET  8'hC0
`define PFC_EVT_MASK_OFFSET 8'hC4

// ----------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------
`define PFC_LED_LSB  28
`define PFC_POL_LSB  24
`define PFC_ROM_LSB  20
`define PFC_DRV_LSB  16
`define PFC_DIR_LSB  8
`define PFC_GPO_LSB  3
`define PFC_DATA_LSB 0
`define PFC_CFG_WMASK 32'h7777_071F
`define PFC_CFG_RESET 32'h0000_0000
`define PFC_EVT_RESET 3'h0

// ----------------------------------------------------------------
// serial rom pin selector codes
// ----------------------------------------------------------------
`define ROM_SEL_ROM      3'h0
`define ROM_SEL_GPO_GPO  3'h1
`define ROM_SEL_GPO_RXDV 3'h3
`define ROM_SEL_TXEN_GPO 3'h5
`define ROM_SEL_TXEN_DV  3'h6
`define ROM_SEL_CLKS     3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SYS_CLK_PERIOD_NS 100
`define PIN_EVENT_MIN_NS  40
`define PIN_EVENT_MIN_CYC \
  (((`PIN_EVENT_MIN_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS) < 1 \
   ? 1 : ((`PIN_EVENT_MIN_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS))

`endif

// ==== logic/pin_function_config_pkg.sv ====
package pin_function_config_pkg;

  // layout of the configuration register, msb first
  typedef struct packed {
    logic       rsvd31;
    logic [2:0] led_function_select;
    logic       rsvd27;
    logic [2:0] pin_event_polarity;
    logic       rsvd23;
    logic [2:0] serial_rom_pin_function;
    logic       rsvd19;
    logic [2:0] pin_driver_type;
    logic [4:0] rsvd15_11;
    logic [2:0] pin_direction;
    logic [2:0] rsvd7_5;
    logic [1:0] output_only_value;
    logic [2:0] pin_value;
  } pin_cfg_s;

  // one pad's drive pair
  typedef struct packed {
    logic oe;
    logic out;
  } pad_drive_s;

endpackage : pin_function_config_pkg

// ==== logic/pin_function_config_port.sv ====
`timescale 1ns/10ps
`include "pin_function_config_defines.svh"

// Summary of operation
// - bits 30:28 put pins 2..0 in LED mode when one, else general use.
// - polarity bits 26:24 choose high or low level as a pin's event.
// - a pin event interrupts only when its enable bit is also set.
// - a pin level counts as event only once seen on two successive 100 ns clock samples.
// - field 22:20 routes rom data and clock pins per the selector table.
// - monitor signals come from the internal phy; tx enable from the mac.
// - bits 18:16 make a pin push-pull when one, open-drain when zero.
// - bits 10:8 make a pin an output when one, input when zero.
// - bits 4 and 3 drive output-only pins b and a when routed.
// - an output pin drives its written bit from field 2:0.
// - reading field 2:0 returns the sampled pin levels.
module pin_function_config_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  output logic             o_irq,
  input  wire logic [2:0]  i_pin_in,
  output logic      [2:0]  o_pin_out,
  output logic      [2:0]  o_pin_oe,
  input  wire logic [2:0]  i_led_drive,
  input  wire logic        i_rom_data_out,
  input  wire logic        i_rom_data_oe,
  input  wire logic        i_rom_clk_out,
  output logic             o_rom_data_in,
  input  wire logic        i_serial_rom_data_pin,
  output logic             o_serial_rom_data_pin,
  output logic             o_serial_rom_data_pin_oe,
  output logic             o_serial_rom_clock_pin,
  output logic             o_serial_rom_clock_pin_oe,
  input  wire logic        i_phy_rx_dv,
  input  wire logic        i_phy_tx_clk,
  input  wire logic        i_phy_rx_clk,
  input  wire logic        i_mac_tx_en
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic pin_function_config_pkg::pad_drive_s pad_drive(
    input logic value,
    input logic push_pull
  );
    pin_function_config_pkg::pad_drive_s d;
    // open drain only pulls low, releases for a one
    d.oe  = push_pull ? 1'b1 : ~value;
    d.out = push_pull ? value : 1'b0;
    return d;
  endfunction : pad_drive

  function automatic logic level_hit(
    input logic level,
    input logic polarity
  );
    return level == polarity;
  endfunction : level_hit

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [3:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_pipe <= 4'h0;
    end else begin
      rst_pipe <= {rst_pipe[2:0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  pin_function_config_pkg::pin_cfg_s cfg;
  logic [2:0]                        evt_status;
  logic [2:0]                        pin_event_enable;
  logic [2:0]                        pin_sync1;
  logic [2:0]                        pin_sync2;
  logic [1:0]                        hold_cnt [3];
  logic [2:0]                        pin_hit;
  logic [2:0]                        pin_event;
  logic                              wr_cfg;
  logic                              wr_sts;
  logic                              wr_mask;

  assign wr_cfg  = i_reg_wr && (i_reg_addr == `PFC_CFG_OFFSET);
  assign wr_sts  = i_reg_wr && (i_reg_addr == `PFC_EVT_STS_OFFSET);
  assign wr_mask = i_reg_wr && (i_reg_addr == `PFC_EVT_MASK_OFFSET);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= `PFC_CFG_RESET;
    end else if (wr_cfg) begin
      // reserved positions never store
      cfg <= i_reg_wdata & `PFC_CFG_WMASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_event_enable <= `PFC_EVT_RESET;
    end else if (wr_mask) begin
      pin_event_enable <= i_reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and event qualification
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync1 <= 3'h0;
      pin_sync2 <= 3'h0;
    end else begin
      pin_sync1 <= i_pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  // a one-cycle sample may be a glitch under 40 ns; wait it out
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        hold_cnt[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!pin_hit[i]) begin
          hold_cnt[i] <= 2'h0;
        end else if (hold_cnt[i] != 2'(`PIN_EVENT_MIN_CYC)) begin
          hold_cnt[i] <= hold_cnt[i] + 2'h1;
        end
      end
    end
  end

  // synchroniser reset value is no pin level; ignore it until refilled
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_hit[i]   = rst_pipe[3] && level_hit(pin_sync2[i],
                               cfg.pin_event_polarity[i]);
      pin_event[i] = pin_hit[i] &&
                     (hold_cnt[i] == 2'(`PIN_EVENT_MIN_CYC));
    end
  end

  // level sensitive: re-sets every cycle the level stays qualified
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status <= `PFC_EVT_RESET;
    end else begin
      evt_status <= (evt_status & ~(wr_sts ? i_reg_wdata[2:0] : 3'h0))
                    | pin_event;
    end
  end

  assign o_irq = |(evt_status & pin_event_enable);

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_reg_addr == `PFC_CFG_OFFSET) begin
      next_rdata = cfg & `PFC_CFG_WMASK;
      next_rdata[2:0] = pin_sync2;
    end else if (i_reg_addr == `PFC_EVT_STS_OFFSET) begin
      next_rdata[2:0] = evt_status;
    end else if (i_reg_addr == `PFC_EVT_MASK_OFFSET) begin
      next_rdata[2:0] = pin_event_enable;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // general purpose pins
  // ----------------------------------------------------------------
  pin_function_config_pkg::pad_drive_s gp_drive [3];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (cfg.led_function_select[i]) begin
        gp_drive[i] = pad_drive(i_led_drive[i],
                                cfg.pin_driver_type[i]);
      end else if (cfg.pin_direction[i]) begin
        gp_drive[i] = pad_drive(cfg.pin_value[i],
                                cfg.pin_driver_type[i]);
      end else begin
        gp_drive[i] = '0;
      end
      o_pin_out[i] = gp_drive[i].out;
      o_pin_oe[i]  = gp_drive[i].oe;
    end
  end

  // ----------------------------------------------------------------
  // serial rom pins
  // ----------------------------------------------------------------
  pin_function_config_pkg::pad_drive_s dio_drive;
  pin_function_config_pkg::pad_drive_s clk_drive;

  // monitor taps are fixed to the internal phy and the mac
  always_comb begin
    dio_drive = '0;
    clk_drive = '0;
    case (cfg.serial_rom_pin_function)
      `ROM_SEL_ROM: begin
        dio_drive.out = i_rom_data_out;
        dio_drive.oe  = i_rom_data_oe;
        clk_drive     = pad_drive(i_rom_clk_out, 1'b1);
      end
      `ROM_SEL_GPO_GPO: begin
        dio_drive = pad_drive(cfg.output_only_value[0], 1'b1);
        clk_drive = pad_drive(cfg.output_only_value[1], 1'b1);
      end
      `ROM_SEL_GPO_RXDV: begin
        dio_drive = pad_drive(cfg.output_only_value[0], 1'b1);
        clk_drive = pad_drive(i_phy_rx_dv, 1'b1);
      end
      `ROM_SEL_TXEN_GPO: begin
        dio_drive = pad_drive(i_mac_tx_en, 1'b1);
        clk_drive = pad_drive(cfg.output_only_value[1], 1'b1);
      end
      `ROM_SEL_TXEN_DV: begin
        dio_drive = pad_drive(i_mac_tx_en, 1'b1);
        clk_drive = pad_drive(i_phy_rx_dv, 1'b1);
      end
      `ROM_SEL_CLKS: begin
        dio_drive = pad_drive(i_phy_tx_clk, 1'b1);
        clk_drive = pad_drive(i_phy_rx_clk, 1'b1);
      end
      default: begin
        // reserved codes keep the defaults: both pins undriven
      end
    endcase
  end

  assign o_serial_rom_data_pin     = dio_drive.out;
  assign o_serial_rom_data_pin_oe  = dio_drive.oe;
  assign o_serial_rom_clock_pin    = clk_drive.out;
  assign o_serial_rom_clock_pin_oe = clk_drive.oe;
  // selector changes mid-cycle would corrupt the rom transfer
  assign o_rom_data_in =
    (cfg.serial_rom_pin_function == `ROM_SEL_ROM) ?
    i_serial_rom_data_pin : 1'b0;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_led_mode;
    @(posedge i_sys_clk) disable iff (!rst_n)
      cfg.led_function_select[0] && cfg.pin_driver_type[0]
      |-> o_pin_oe[0] && (o_pin_out[0] == i_led_drive[0]);
  endproperty
  a_led_mode: assert property (p_led_mode)
    else $error("led mode does not follow led source");

  property p_event_sets;
    @(posedge i_sys_clk) disable iff (!rst_n)
      pin_hit[0] [*2] |=> evt_status[0];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("held pin level did not set status");

  property p_event_persist;
    @(posedge i_sys_clk) disable iff (!rst_n)
      $rose(evt_status[1])
      |-> $past(pin_hit[1], 1) && $past(pin_hit[1], 2);
  endproperty
  a_event_persist: assert property (p_event_persist)
    else $error("status set by a short pulse");

  property p_irq_masked;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (pin_event_enable == 3'h0) |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt with all enables clear");

  property p_gpo_route;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (cfg.serial_rom_pin_function == `ROM_SEL_GPO_GPO)
      |-> o_serial_rom_data_pin_oe && o_serial_rom_clock_pin_oe
          && (o_serial_rom_data_pin == cfg.output_only_value[0])
          && (o_serial_rom_clock_pin == cfg.output_only_value[1]);
  endproperty
  a_gpo_route: assert property (p_gpo_route)
    else $error("output-only values not on rom pins");

  property p_clk_monitor;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (cfg.serial_rom_pin_function == `ROM_SEL_CLKS)
      |-> (o_serial_rom_data_pin == i_phy_tx_clk)
          && (o_serial_rom_clock_pin == i_phy_rx_clk);
  endproperty
  a_clk_monitor: assert property (p_clk_monitor)
    else $error("phy clocks not routed to rom pins");

  property p_open_drain;
    @(posedge i_sys_clk) disable iff (!rst_n)
      cfg.pin_direction[1] && !cfg.led_function_select[1]
      && !cfg.pin_driver_type[1]
      |-> !o_pin_out[1] && (o_pin_oe[1] == !cfg.pin_value[1]);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drives high");

  property p_input_off;
    @(posedge i_sys_clk) disable iff (!rst_n)
      !cfg.pin_direction[2] && !cfg.led_function_select[2]
      |-> !o_pin_oe[2];
  endproperty
  a_input_off: assert property (p_input_off)
    else $error("input pin is driven");

  property p_gpo_store;
    @(posedge i_sys_clk) disable iff (!rst_n)
      wr_cfg |=> cfg.output_only_value == $past(i_reg_wdata[4:3]);
  endproperty
  a_gpo_store: assert property (p_gpo_store)
    else $error("output-only bits not stored");

  property p_push_pull;
    @(posedge i_sys_clk) disable iff (!rst_n)
      wr_cfg && i_reg_wdata[`PFC_DIR_LSB] && i_reg_wdata[`PFC_DRV_LSB]
      && !i_reg_wdata[`PFC_LED_LSB]
      |=> o_pin_oe[0] && (o_pin_out[0] == $past(i_reg_wdata[0]));
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("written value not driven on pin");

  property p_read_level;
    @(posedge i_sys_clk) disable iff (!rst_n)
      i_reg_rd && (i_reg_addr == `PFC_CFG_OFFSET) && $past(rst_n, 3)
      |=> o_reg_rdata[2:0] == $past(i_pin_in, 3);
  endproperty
  a_read_level: assert property (p_read_level)
    else $error("read does not return synchronised pin level");

  property p_reserved_zero;
    @(posedge i_sys_clk) disable iff (!rst_n)
      i_reg_rd && (i_reg_addr == `PFC_CFG_OFFSET)
      |=> (o_reg_rdata & ~`PFC_CFG_WMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read non-zero");

endmodule : pin_function_config_port

// ==== verif/pin_pad_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------
// board side: pads, pull-ups and an outside driver
// ----------------------------------------------------------------
module pin_pad_model (
  input  wire logic [2:0] i_pin_out,
  input  wire logic [2:0] i_pin_oe,
  input  wire logic [2:0] i_ext_val,
  input  wire logic [2:0] i_ext_en,
  input  wire logic       i_rom_out,
  input  wire logic       i_rom_oe,
  output logic      [2:0] o_pin_level,
  output logic            o_rom_level
);
  // released lines rise through pull-ups; a fight reads unknown
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (i_pin_oe[i] && i_ext_en[i])
        o_pin_level[i] = 1'bx;
      else if (i_pin_oe[i])
        o_pin_level[i] = i_pin_out[i];
      else if (i_ext_en[i])
        o_pin_level[i] = i_ext_val[i];
      else
        o_pin_level[i] = 1'b1;
    end
    o_rom_level = i_rom_oe ? i_rom_out : 1'b1;
  end
endmodule : pin_pad_model

// ==== verif/pin_function_config_port_bench.sv ====
`timescale 1ns/10ps
`include "pin_function_config_defines.svh"
`define CHK(g, e) check(32'(g), 32'(e))

module pin_function_config_port_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  led = 3'h0;
  logic [2:0]  ext_val = 3'h0;
  logic [2:0]  ext_en = 3'h0;
  logic        rom_do = 1'b0;
  logic        rom_doe = 1'b0;
  logic        rom_clk = 1'b0;
  logic        rx_dv = 1'b0;
  logic        tx_clk = 1'b0;
  logic        rx_clk = 1'b0;
  logic        tx_en = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic [2:0]  pin_out;
  logic [2:0]  pin_oe;
  logic [2:0]  pin_lvl;
  logic        rom_in;
  logic        rom_lvl;
  logic        dat_o;
  logic        dat_oe;
  logic        clk_o;
  logic        clk_oe;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #50 clk = ~clk;

  pin_function_config_port uut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_irq(irq), .i_pin_in(pin_lvl),
    .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_led_drive(led),
    .i_rom_data_out(rom_do), .i_rom_data_oe(rom_doe),
    .i_rom_clk_out(rom_clk), .o_rom_data_in(rom_in),
    .i_serial_rom_data_pin(rom_lvl), .o_serial_rom_data_pin(dat_o),
    .o_serial_rom_data_pin_oe(dat_oe), .o_serial_rom_clock_pin(clk_o),
    .o_serial_rom_clock_pin_oe(clk_oe), .i_phy_rx_dv(rx_dv),
    .i_phy_tx_clk(tx_clk), .i_phy_rx_clk(rx_clk), .i_mac_tx_en(tx_en));

  pin_pad_model pads (
    .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .i_rom_out(dat_o), .i_rom_oe(dat_oe),
    .o_pin_level(pin_lvl), .o_rom_level(rom_lvl));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr32

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e);
  endtask : rchk

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(`PFC_CFG_OFFSET, 32'h0000_0007);
    rchk(`PFC_EVT_MASK_OFFSET, 32'h0000_0000);
    rchk(`PFC_EVT_STS_OFFSET, 32'h0000_0000);
    rchk(8'h10, 32'h0000_0000);
    `CHK(pin_oe, 3'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_led;
    wr32(`PFC_CFG_OFFSET, 32'hFFFF_FFFF);
    cyc(3);
    rchk(`PFC_CFG_OFFSET, 32'h7777_0718);
    @(posedge clk);
    led <= 3'h5;
    cyc(3);
    `CHK(pin_out, 3'h5);
    rchk(`PFC_CFG_OFFSET, 32'h7777_071D);
    wr32(`PFC_CFG_OFFSET, 32'h6777_0718);
    @(negedge clk);
    `CHK(pin_out, 3'h4);
    $display("test led done");
  endtask : t_led

  task automatic t_drive;
    wr32(`PFC_CFG_OFFSET, 32'h0007_0705);
    @(negedge clk);
    `CHK({pin_oe, pin_out}, 6'h3D);
    wr32(`PFC_CFG_OFFSET, 32'h0000_0705);
    @(negedge clk);
    `CHK({pin_oe, pin_out[1]}, 4'h4);
    wr32(`PFC_CFG_OFFSET, 32'h0000_0007);
    ext_en  <= 3'h7;
    ext_val <= 3'h2;
    cyc(3);
    `CHK(pin_oe, 3'h0);
    rchk(`PFC_CFG_OFFSET, 32'h0000_0002);
    $display("test drive done");
  endtask : t_drive

  function automatic logic [3:0] rom_exp(input logic [2:0] s,
                                         input logic [1:0] k);
    case (s)
      3'h0:    rom_exp = {k[0], k[0] & k[1], 1'b1, k[0] ^ k[1]};
      3'h1:    rom_exp = {1'b1, k[0], 1'b1, k[1]};
      3'h3:    rom_exp = {1'b1, k[0], 1'b1, ~k[0]};
      3'h5:    rom_exp = {1'b1, ~k[1], 1'b1, k[1]};
      3'h6:    rom_exp = {1'b1, ~k[1], 1'b1, ~k[0]};
      default: rom_exp = {1'b1, k[0] ^ k[1], 1'b1, ~(k[0] ^ k[1])};
    endcase
  endfunction : rom_exp

  task automatic t_rom;
    logic [2:0] codes [6];
    logic [1:0] k;
    logic [3:0] got;
    codes = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    for (int c = 0; c < 6; c++) begin
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        k = 2'(p);
        rom_doe <= k[0];
        rom_do  <= ~(k[0] ^ k[1]);
        rom_clk <= k[0] ^ k[1];
        rx_dv   <= ~k[0];
        tx_en   <= ~k[1];
        tx_clk  <= k[0] ^ k[1];
        rx_clk  <= ~(k[0] ^ k[1]);
        // no rom cycle runs here, so switching is allowed
        wr32(`PFC_CFG_OFFSET, {9'h000, codes[c], 15'h0000, k, 3'h0});
        @(negedge clk);
        got = {dat_oe, dat_oe & dat_o, clk_oe, clk_o};
        `CHK(got, rom_exp(codes[c], k));
        `CHK(rom_in, codes[c] == 3'h0 ? (k[0] ? k[1] : 1'b1) : 1'b0);
      end
    end
    $display("test rom done");
  endtask : t_rom

  task automatic t_event;
    @(posedge clk);
    ext_val <= 3'h0;
    wr32(`PFC_EVT_MASK_OFFSET, 32'h0000_0000);
    wr32(`PFC_CFG_OFFSET, 32'h0700_0000);
    cyc(4);
    wr32(`PFC_EVT_STS_OFFSET, 32'h0000_0007);
    rchk(`PFC_EVT_STS_OFFSET, 32'h0000_0000);
    @(posedge clk);
    ext_val <= 3'h1;
    @(posedge clk);
    ext_val <= 3'h0;
    cyc(5);
    rchk(`PFC_EVT_STS_OFFSET, 32'h0000_0000);
    @(posedge clk);
    ext_val <= 3'h1;
    cyc(5);
    rchk(`PFC_EVT_STS_OFFSET, 32'h0000_0001);
    `CHK(irq, 1'b0);
    wr32(`PFC_EVT_MASK_OFFSET, 32'h0000_0001);
    @(negedge clk);
    `CHK(irq, 1'b1);
    @(posedge clk);
    ext_val <= 3'h0;
    cyc(4);
    wr32(`PFC_EVT_STS_OFFSET, 32'h0000_0001);
    @(negedge clk);
    `CHK(irq, 1'b0);
    wr32(`PFC_CFG_OFFSET, 32'h0500_0000);
    cyc(5);
    rchk(`PFC_EVT_STS_OFFSET, 32'h0000_0002);
    `CHK(irq, 1'b0);
    $display("test event done");
  endtask : t_event

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    cyc(3);
    t_reset();
    t_led();
    t_drive();
    t_rom();
    t_event();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : pin_function_config_port_bench
